// >>> bpr_pkg.sv
// package: offsets, field positions, reset values and types of the break/low-power/reset unit
package bpr_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // register byte offsets on the apb bus
    localparam logic [7:0] OFS_BREAK_WAIT_STATUS = 8'h00;
    localparam logic [7:0] OFS_RESET_SOURCE_STATUS = 8'h04;
    localparam logic [7:0] OFS_BREAK_FLAG_CLEAR_CONTROL = 8'h08;
    localparam logic [7:0] OFS_LOW_POWER_CONFIG = 8'h0C;

    ////////////////////////////////////////////////////////////////////////////////
    // field positions inside the byte-wide registers
    localparam int BIT_BREAK_EXITED_WAIT = 0;
    localparam int BIT_POWER_ON = 7;
    localparam int BIT_PIN = 6;
    localparam int BIT_WATCHDOG = 5;
    localparam int BIT_BAD_INSTRUCTION = 4;
    localparam int BIT_BAD_FETCH_LOCATION = 3;
    localparam int BIT_LOW_VOLTAGE = 1;
    localparam int BIT_BREAK_FLAG_CLEAR_ENABLE = 7;
    localparam int BIT_WATCHDOG_DISABLE = 0;
    localparam int BIT_SHORT_RECOVERY_SELECT = 1;

    ////////////////////////////////////////////////////////////////////////////////
    // values after reset
    localparam logic [7:0] RST_BREAK_WAIT_STATUS = 8'h00;
    localparam logic [7:0] RST_RESET_SOURCE_STATUS = 8'h80;
    localparam logic [7:0] RST_BREAK_FLAG_CLEAR_CONTROL = 8'h00;
    localparam logic [7:0] RST_LOW_POWER_CONFIG = 8'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // counts
    localparam int CNT_WIDTH = 12;
    localparam int LONG_RECOVERY_XTAL = 4096;
    localparam int SHORT_RECOVERY_XTAL = 32;
    localparam int XTAL_DIV_DEFAULT = 4;

    ////////////////////////////////////////////////////////////////////////////////
    // sequencer states, gray along run -> stop -> recover; recover -> run flips both bits
    typedef enum logic [1:0] {
        BPR_RUN = 2'h0,
        BPR_STOP = 2'h1,
        BPR_RECOVER = 2'h3,
        BPR_WAIT = 2'h2
    } bpr_state_t;

    // reset sources other than power-on, one-cycle pulses
    typedef struct packed {
        logic pin;
        logic watchdog;
        logic bad_instruction;
        logic bad_fetch_location;
        logic low_voltage;
    } bpr_rst_src_t;

    // clock gates driven toward the cpu, peripherals and clock generator
    typedef struct packed {
        logic cpu;
        logic periph;
        logic base_clock;
        logic crystal_clock;
    } bpr_clk_gate_t;

endpackage

// >>> bpr_xtal_div.sv
// crystal-rate enable divider for the break/low-power/reset unit
`timescale 1ns/1ps
`default_nettype none
module bpr_xtal_div #(
    parameter int DIV = bpr_pkg::XTAL_DIV_DEFAULT
) (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // crystal-rate tick, one mclk cycle wide
    output logic tick
);
    localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [W-1:0] LAST = W'(DIV - 1);

    logic [W-1:0] div_q; // position inside one crystal period

    ////////////////////////////////////////////////////////////////////////////////
    // free-running divider; the tick marks the crystal falling edge
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            div_q <= '0;
            tick <= 1'b0;
        end else begin
            if (div_q == LAST) begin
                div_q <= '0;
            end else begin
                div_q <= div_q + W'(1);
            end
            tick <= (div_q == LAST);
        end
    end
endmodule
`default_nettype wire

// >>> bpr_int_counter.sv
// integration counter: times stop recovery and prescales the watchdog
`timescale 1ns/1ps
`default_nettype none
module bpr_int_counter #(
    parameter int WIDTH = bpr_pkg::CNT_WIDTH
) (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // control
    input wire logic tick,
    input wire logic clear,
    // state
    output logic [WIDTH-1:0] count,
    output logic ovf
);
    ////////////////////////////////////////////////////////////////////////////////
    // counts crystal ticks; clear holds it at zero and wins over a tick
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            count <= '0;
            ovf <= 1'b0;
        end else if (clear) begin
            count <= '0;
            ovf <= 1'b0;
        end else begin
            if (tick) begin
                count <= count + WIDTH'(1);
            end
            ovf <= tick && (&count);
        end
    end
endmodule
`default_nettype wire

// >>> bpr_top.sv
// break entry, flag protection, wait/stop sequencing and status registers
//
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module bpr_top #(
    parameter int XTAL_DIV = bpr_pkg::XTAL_DIV_DEFAULT,
    parameter int LONG_RECOVERY = bpr_pkg::LONG_RECOVERY_XTAL,
    parameter int SHORT_RECOVERY = bpr_pkg::SHORT_RECOVERY_XTAL
) (
    // clock and reset; nrst is the power-on reset
    input wire logic mclk,
    input wire logic nrst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // cpu core
    input wire logic wait_exec,
    input wire logic stop_exec,
    input wire logic cpu_irq,
    input wire logic module_irq,
    input wire logic break_done,
    output logic force_swi_vector,
    output logic clear_imask,
    output logic stack_start,
    // break module
    input wire logic break_irq,
    output logic break_module_enable,
    // other modules' status flags
    output logic flag_clear_allow,
    // reset sources other than power-on
    input wire bpr_pkg::bpr_rst_src_t rst_src,
    // clock generator gates and watchdog
    output bpr_pkg::bpr_clk_gate_t clk_gate,
    output logic watchdog_run,
    output logic watchdog_tick
);
    localparam int CW = bpr_pkg::CNT_WIDTH;
    localparam logic [CW-1:0] LONG_LAST = CW'(LONG_RECOVERY - 1);
    localparam logic [CW-1:0] SHORT_LAST = CW'(SHORT_RECOVERY - 1);

    ////////////////////////////////////////////////////////////////////////////////
    // declarations
    bpr_pkg::bpr_state_t state_q; // low-power sequencer state
    logic break_q; // cpu is in the break state
    logic [7:0] bws_q; // break wait status byte
    logic [7:0] rss_q; // reset source status byte
    logic [7:0] bfc_q; // break flag clear control byte
    logic [7:0] cfg_q; // low-power configuration byte
    logic xtal_tick; // crystal falling-edge tick
    logic xtal_tick_g; // tick as seen by the counter, gated in stop
    logic cnt_clear; // hold the integration counter at zero
    logic [CW-1:0] cnt; // integration counter value
    logic cnt_ovf; // counter wrap, one cycle
    logic any_rst; // a reset source other than power-on
    logic low_power_exit; // wait exit condition
    logic recover_done; // recovery period finished
    logic [CW-1:0] recover_last; // last count of the selected delay
    logic wr_en; // apb write completes this edge
    logic rd_en; // apb read completes this edge
    logic setup; // apb setup phase
    logic hit; // address maps to a register
    logic [7:0] rd_byte; // selected register for read data

    ////////////////////////////////////////////////////////////////////////////////
    // helper terms
    assign any_rst = |rst_src;
    assign low_power_exit = cpu_irq | break_irq;
    assign recover_last = cfg_q[bpr_pkg::BIT_SHORT_RECOVERY_SELECT] ? SHORT_LAST
                                                                    : LONG_LAST;
    assign recover_done = (state_q == bpr_pkg::BPR_RECOVER) && xtal_tick_g
                          && (cnt == recover_last);
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready && pwrite;
    assign rd_en = psel && penable && pready && !pwrite;
    // crystal stays quiet in stop, so the counter sees no ticks there
    assign xtal_tick_g = xtal_tick && (state_q != bpr_pkg::BPR_STOP);
    // counter is held from the stop instruction until recovery begins
    assign cnt_clear = (state_q == bpr_pkg::BPR_STOP)
                       || (state_q == bpr_pkg::BPR_RUN && stop_exec);

    ////////////////////////////////////////////////////////////////////////////////
    // crystal-rate enable and the integration counter
    bpr_xtal_div #(
        .DIV(XTAL_DIV)
    ) u_div (
        .mclk(mclk),
        .nrst(nrst),
        .tick(xtal_tick)
    );

    // pin reset does not touch the counter: it free-runs after any reset
    bpr_int_counter #(
        .WIDTH(CW)
    ) u_cnt (
        .mclk(mclk),
        .nrst(nrst),
        .tick(xtal_tick_g),
        .clear(cnt_clear),
        .count(cnt),
        .ovf(cnt_ovf)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // low-power sequencer
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_q <= bpr_pkg::BPR_RUN;
        end else if (any_rst) begin
            // every reset pulls the part back to run, from wait or stop
            state_q <= bpr_pkg::BPR_RUN;
        end else begin
            case (state_q)
                bpr_pkg::BPR_RUN: begin
                    if (stop_exec) begin
                        state_q <= bpr_pkg::BPR_STOP;
                    end else if (wait_exec) begin
                        state_q <= bpr_pkg::BPR_WAIT;
                    end
                end
                bpr_pkg::BPR_WAIT: begin
                    if (low_power_exit) begin
                        state_q <= bpr_pkg::BPR_RUN;
                    end
                end
                bpr_pkg::BPR_STOP: begin
                    // only a module request wakes stop; break is idle here
                    if (module_irq) begin
                        state_q <= bpr_pkg::BPR_RECOVER;
                    end
                end
                bpr_pkg::BPR_RECOVER: begin
                    if (recover_done) begin
                        state_q <= bpr_pkg::BPR_RUN;
                    end
                end
                default: begin
                    state_q <= bpr_pkg::BPR_RUN;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // cpu side pulses: mask clear, stacking start
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            clear_imask <= 1'b0;
            stack_start <= 1'b0;
        end else begin
            // both instructions open the mask so a wake interrupt is taken
            clear_imask <= (state_q == bpr_pkg::BPR_RUN) && !any_rst
                           && (wait_exec || stop_exec);
            // wait: stacking in the cycle after the waking interrupt
            if (state_q == bpr_pkg::BPR_WAIT && cpu_irq && !any_rst) begin
                stack_start <= 1'b1;
            end else if (recover_done && !any_rst) begin
                stack_start <= 1'b1;
            end else begin
                stack_start <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // clock gates toward cpu, peripherals and clock generator
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            clk_gate <= '1;
        end else begin
            case (state_q)
                bpr_pkg::BPR_WAIT: begin
                    clk_gate.cpu <= low_power_exit || any_rst;
                    clk_gate.periph <= 1'b1;
                    clk_gate.base_clock <= 1'b1;
                    clk_gate.crystal_clock <= 1'b1;
                end
                bpr_pkg::BPR_STOP: begin
                    clk_gate.cpu <= any_rst;
                    clk_gate.periph <= any_rst;
                    clk_gate.base_clock <= any_rst;
                    // oscillator restarts as soon as recovery begins
                    clk_gate.crystal_clock <= any_rst || module_irq;
                end
                bpr_pkg::BPR_RECOVER: begin
                    // base clock stays off until the oscillator has settled
                    clk_gate.cpu <= recover_done || any_rst;
                    clk_gate.periph <= recover_done || any_rst;
                    clk_gate.base_clock <= recover_done || any_rst;
                    clk_gate.crystal_clock <= 1'b1;
                end
                default: begin
                    // run: the instruction gates the cpu from the next cycle
                    clk_gate.cpu <= any_rst || !(wait_exec || stop_exec);
                    clk_gate.periph <= any_rst || !stop_exec;
                    clk_gate.base_clock <= any_rst || !stop_exec;
                    clk_gate.crystal_clock <= any_rst || !stop_exec;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // break state and vector forcing; break module idle through stop
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            break_q <= 1'b0;
            force_swi_vector <= 1'b0;
            break_module_enable <= 1'b1;
        end else begin
            force_swi_vector <= 1'b0;
            if (any_rst) begin
                break_q <= 1'b0;
            end else if (break_irq && break_module_enable && !break_q) begin
                break_q <= 1'b1;
                force_swi_vector <= 1'b1;
            end else if (break_done) begin
                break_q <= 1'b0;
            end
            // only the enable drops; break register contents live outside
            break_module_enable <= any_rst
                || ((state_q == bpr_pkg::BPR_RUN) && !stop_exec)
                || (state_q == bpr_pkg::BPR_WAIT);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // flag protection: a clear, or the second step of a two-step clear,
    // happens in other modules only when this is high; a first step taken
    // before break is left pending there and completes once this returns
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            flag_clear_allow <= 1'b1;
        end else begin
            flag_clear_allow <= !break_q
                || bfc_q[bpr_pkg::BIT_BREAK_FLAG_CLEAR_ENABLE];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // watchdog feed from the counter wrap
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            watchdog_run <= 1'b1;
            watchdog_tick <= 1'b0;
        end else begin
            // enabled watchdog keeps running through wait; stop freezes it
            watchdog_run <= !cfg_q[bpr_pkg::BIT_WATCHDOG_DISABLE]
                            && (state_q != bpr_pkg::BPR_STOP);
            watchdog_tick <= cnt_ovf && !cfg_q[bpr_pkg::BIT_WATCHDOG_DISABLE];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // break wait status: break-exited-wait flag
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            bws_q <= bpr_pkg::RST_BREAK_WAIT_STATUS;
        end else if (any_rst) begin
            bws_q <= bpr_pkg::RST_BREAK_WAIT_STATUS;
        end else if (state_q == bpr_pkg::BPR_WAIT && break_irq) begin
            // a new break wins over a clearing write in the same cycle
            bws_q[bpr_pkg::BIT_BREAK_EXITED_WAIT] <= 1'b1;
        end else if (wr_en && paddr == bpr_pkg::OFS_BREAK_WAIT_STATUS
                     && !pwdata[bpr_pkg::BIT_BREAK_EXITED_WAIT]) begin
            bws_q[bpr_pkg::BIT_BREAK_EXITED_WAIT] <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // reset source status: power-on alone via nrst, others accumulate
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rss_q <= bpr_pkg::RST_RESET_SOURCE_STATUS;
        end else begin
            if (rd_en && paddr == bpr_pkg::OFS_RESET_SOURCE_STATUS) begin
                rss_q <= 8'h00;
            end
            // sets come last so a reset landing on the read is kept
            if (rst_src.pin) begin
                rss_q[bpr_pkg::BIT_PIN] <= 1'b1;
            end
            if (rst_src.watchdog) begin
                rss_q[bpr_pkg::BIT_WATCHDOG] <= 1'b1;
            end
            if (rst_src.bad_instruction) begin
                rss_q[bpr_pkg::BIT_BAD_INSTRUCTION] <= 1'b1;
            end
            if (rst_src.bad_fetch_location) begin
                rss_q[bpr_pkg::BIT_BAD_FETCH_LOCATION] <= 1'b1;
            end
            if (rst_src.low_voltage) begin
                rss_q[bpr_pkg::BIT_LOW_VOLTAGE] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // software-written control: flag-clear enable and low-power config
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            bfc_q <= bpr_pkg::RST_BREAK_FLAG_CLEAR_CONTROL;
            cfg_q <= bpr_pkg::RST_LOW_POWER_CONFIG;
        end else if (wr_en) begin
            if (paddr == bpr_pkg::OFS_BREAK_FLAG_CLEAR_CONTROL) begin
                bfc_q[bpr_pkg::BIT_BREAK_FLAG_CLEAR_ENABLE] <=
                    pwdata[bpr_pkg::BIT_BREAK_FLAG_CLEAR_ENABLE];
            end else if (paddr == bpr_pkg::OFS_LOW_POWER_CONFIG) begin
                cfg_q[bpr_pkg::BIT_WATCHDOG_DISABLE] <= pwdata[bpr_pkg::BIT_WATCHDOG_DISABLE];
                cfg_q[bpr_pkg::BIT_SHORT_RECOVERY_SELECT] <=
                    pwdata[bpr_pkg::BIT_SHORT_RECOVERY_SELECT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read mux; spare bits are never written so they read zero
    always_comb begin
        hit = 1'b1;
        if (paddr == bpr_pkg::OFS_BREAK_WAIT_STATUS) begin
            rd_byte = bws_q;
        end else if (paddr == bpr_pkg::OFS_RESET_SOURCE_STATUS) begin
            rd_byte = rss_q;
        end else if (paddr == bpr_pkg::OFS_BREAK_FLAG_CLEAR_CONTROL) begin
            rd_byte = bfc_q;
        end else if (paddr == bpr_pkg::OFS_LOW_POWER_CONFIG) begin
            rd_byte = cfg_q;
        end else begin
            rd_byte = 8'h00;
            hit = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // apb answer: data latched in setup, one access cycle, no wait states
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setup;
            pslverr <= setup && !hit;
            if (setup && !pwrite) begin
                prdata <= {24'h00_0000, rd_byte};
            end else if (!psel) begin
                prdata <= 32'h0000_0000;
            end
        end
    end
endmodule
`default_nettype wire

// >>> bpr_core_model.sv
// partner: break module and cpu break handling facing the unit
`timescale 1ns/1ps
`default_nettype none
module bpr_core_model #(
    parameter int BRK_LEN = 40
) (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // request from the bench and answer from the unit
    input wire logic go_break,
    input wire logic force_swi_vector,
    // toward the unit
    output logic break_irq,
    output logic break_done
);
    int cnt; // cycles left in the break handler
    ////////////////////////////////////////////////////////////////////////////////
    // request held until the unit vectors; a slow handler keeps break open long
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            break_irq <= 1'b0;
            break_done <= 1'b0;
            cnt <= 0;
        end else begin
            break_done <= 1'b0;
            if (go_break) begin
                break_irq <= 1'b1;
            end
            if (force_swi_vector) begin
                break_irq <= 1'b0;
                cnt <= BRK_LEN;
            end else if (cnt == 1) begin
                break_done <= 1'b1;
                cnt <= 0;
            end else if (cnt > 1) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule
`default_nettype wire

// >>> bpr_monitor.sv
// checker: port timing of wait, stop and break sequencing
`timescale 1ns/1ps
`default_nettype none
module bpr_monitor (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // cpu and break side
    input wire logic wait_exec,
    input wire logic stop_exec,
    input wire logic cpu_irq,
    input wire logic module_irq,
    input wire logic break_irq,
    input wire logic force_swi_vector,
    input wire logic clear_imask,
    input wire logic stack_start,
    input wire logic break_module_enable,
    // resets and gates
    input wire bpr_pkg::bpr_rst_src_t rst_src,
    input wire bpr_pkg::bpr_clk_gate_t clk_gate
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    // states seen through the gates only
    wire logic run = clk_gate.cpu;
    wire logic waiting = !clk_gate.cpu && clk_gate.periph;
    wire logic stopped = !clk_gate.crystal_clock;
    wire logic quiet = (rst_src == '0);
    ////////////////////////////////////////////////////////////////////////////////
    a_entry_mask_gate: assert property (run && (wait_exec || stop_exec) && quiet
        |=> clear_imask && !clk_gate.cpu) else $error("entry without mask clear");
    a_wait_periph_on: assert property (run && wait_exec && !stop_exec && quiet
        |=> clk_gate.periph) else $error("peripherals stopped in wait");
    a_stop_gates_off: assert property (run && stop_exec && quiet
        |=> !clk_gate.base_clock && !clk_gate.crystal_clock) else $error("clocks on in stop");
    a_wait_irq_stack: assert property (waiting && cpu_irq && quiet
        |=> clk_gate.cpu && stack_start) else $error("late wake from wait");
    a_wait_break_exit: assert property (waiting && break_irq && !cpu_irq && quiet
        |=> clk_gate.cpu && !stack_start) else $error("break did not end wait");
    a_stop_holds: assert property (stopped && !module_irq && quiet
        |=> stopped) else $error("stop left without cause");
    a_stop_wakes: assert property (stopped && module_irq && quiet
        |=> clk_gate.crystal_clock && !clk_gate.cpu) else $error("no recovery start");
    a_break_idle_stop: assert property (!clk_gate.base_clock
        |-> !break_module_enable) else $error("break module live in stop");
    a_vector_cause: assert property ($rose(force_swi_vector)
        |-> $past(break_irq)) else $error("vector forced without break");
    c_wait_wake: cover property (waiting && cpu_irq);
    c_stop_wake: cover property (stopped && module_irq);
    c_break_entry: cover property ($rose(force_swi_vector));
endmodule
`default_nettype wire

// >>> bpr_top_test.sv
// testbench: registers, break, wait and stop sequencing of the unit
`timescale 1ns/1ps
`default_nettype none
module bpr_top_test;
    logic mclk, nrst, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic wait_exec, stop_exec, cpu_irq, module_irq, go_break, break_irq, break_done;
    logic force_swi_vector, clear_imask, stack_start, break_module_enable;
    logic flag_clear_allow, watchdog_run, watchdog_tick;
    bpr_pkg::bpr_rst_src_t rst_src;
    bpr_pkg::bpr_clk_gate_t clk_gate;
    int fail_count = 0;
    int cmp_count = 0;
    int n;
    // short counts keep the stop recovery walk brief
    bpr_top #(.XTAL_DIV(2), .LONG_RECOVERY(64), .SHORT_RECOVERY(8)) i_bpr_top (.mclk, .nrst,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .wait_exec,
        .stop_exec, .cpu_irq, .module_irq, .break_done, .force_swi_vector, .clear_imask,
        .stack_start, .break_irq, .break_module_enable, .flag_clear_allow, .rst_src,
        .clk_gate, .watchdog_run, .watchdog_tick);
    bpr_core_model #(.BRK_LEN(40)) i_bpr_core_model (.mclk, .nrst, .go_break,
        .force_swi_vector, .break_irq, .break_done);
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task tally_and_finish;
        if (fail_count == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // one apb transfer; the request stands until pready is seen
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        k = 0;
        do begin @(posedge mclk); k++; end while (pready !== 1'b1 && k < 16);
        if (k >= 16) begin fail_count++; tally_and_finish; end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task pulse_rst(input logic [4:0] v);
        @(posedge mclk) rst_src <= v;
        @(posedge mclk) rst_src <= '0;
    endtask
    // cycles until stacking starts, bounded
    task wait_stack;
        n = 0;
        while (stack_start !== 1'b1 && n < 1000) begin @(posedge mclk); n++; end
        if (n >= 1000) begin fail_count++; tally_and_finish; end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {nrst, psel, penable, pwrite, paddr, pwdata, rst_src} = '0;
        {wait_exec, stop_exec, cpu_irq, module_irq, go_break} = '0;
        repeat (4) @(posedge mclk);
        nrst <= 1'b1;
        apb(0, 8'h04, 0); chk(rd, 32'h80);
        apb(0, 8'h04, 0); chk(rd, 32'h00);
        apb(1, 8'h08, 32'hFFFF_FFFF); apb(0, 8'h08, 0); chk(rd, 32'h80);
        apb(1, 8'h10, 32'hFF); chk(err, 1);
        for (int i = 0; i < 5; i++) begin
            pulse_rst(5'h10 >> i);
            apb(0, 8'h04, 0); chk(rd, (i < 4) ? (32'h40 >> i) : 32'h02);
        end
        pulse_rst(5'h10); pulse_rst(5'h01);
        apb(0, 8'h04, 0); chk(rd, 32'h42);
        // wait, then an enabled interrupt wakes the cpu
        @(posedge mclk) wait_exec <= 1'b1;
        @(posedge mclk) wait_exec <= 1'b0;
        repeat (2) @(posedge mclk);
        chk(clk_gate, 32'h7); chk(watchdog_run, 1);
        @(posedge mclk) cpu_irq <= 1'b1;
        wait_stack; cpu_irq <= 1'b0; chk(32'(n), 2);
        // break ends a wait; flags protected until clearing is enabled
        apb(1, 8'h08, 0);
        @(posedge mclk) wait_exec <= 1'b1;
        @(posedge mclk) wait_exec <= 1'b0;
        @(posedge mclk) go_break <= 1'b1;
        @(posedge mclk) go_break <= 1'b0;
        repeat (4) @(posedge mclk);
        chk(flag_clear_allow, 0);
        apb(0, 8'h00, 0); chk(rd, 1);
        apb(1, 8'h08, 32'h80); repeat (2) @(posedge mclk); chk(flag_clear_allow, 1);
        apb(1, 8'h00, 0); apb(0, 8'h00, 0); chk(rd, 0);
        apb(1, 8'h08, 0); repeat (40) @(posedge mclk);
        chk(flag_clear_allow, 1);
        // stop with long then short recovery
        for (int s = 0; s < 2; s++) begin
            apb(1, 8'h0C, 32'(s * 3));
            @(posedge mclk) stop_exec <= 1'b1;
            @(posedge mclk) stop_exec <= 1'b0;
            repeat (3) @(posedge mclk);
            chk(clk_gate, 0); chk(break_module_enable, 0);
            @(posedge mclk) module_irq <= 1'b1;
            wait_stack; module_irq <= 1'b0;
            chk(32'(n >= (s ? 14 : 126) && n <= (s ? 22 : 134)), 1);
        end
        chk(watchdog_run, 0);
        apb(1, 8'h0C, 0); n = 0;
        while (watchdog_tick !== 1'b1 && n < 9000) begin @(posedge mclk); n++; end
        chk(32'(n < 9000), 1);
        tally_and_finish;
    end
endmodule
bind bpr_top bpr_monitor i_bpr_monitor (.mclk, .nrst, .wait_exec, .stop_exec, .cpu_irq,
    .module_irq, .break_irq, .force_swi_vector, .clear_imask, .stack_start,
    .break_module_enable, .rst_src, .clk_gate);
`default_nettype wire
